//--- hw/pib_map.svh
// register offsets, field positions, reset values and constants of the packet input block
`ifndef PIB_MAP_SVH
`define PIB_MAP_SVH
`define PIB_CTRL_OFF      12'h000
`define PIB_PAD_OFF       12'h004
`define PIB_BACK_OFF      12'h008
`define PIB_PKT_OFF       12'h00C
`define PIB_GEO_OFF       12'h010
`define PIB_GO_OFF        12'h014
`define PIB_PTR_LO_OFF    12'h018
`define PIB_PTR_HI_OFF    12'h01C
`define PIB_WQE_OFF       12'h020
`define PIB_TAG_OFF       12'h024
`define PIB_STAT_OFF      12'h028
`define PIB_PORT_OFF      12'h02C
`define PIB_CTRL_RST      32'h0000_0000
`define PIB_SZ_LSB        40
`define PIB_SZ_MSB        55
`define PIB_POOL_LSB      56
`define PIB_POOL_MSB      58
`define PIB_BACK_LSB      59
`define PIB_BACK_MSB      62
`define PIB_SIZE_ERR      16'h0008
`define PIB_ERR_LEN_MAX   16'h0080
`define PIB_V6_BASE       8'h08
`define PIB_V4_BASE       8'h04
`define PIB_MAX_BUFS      8'hFF
`endif

//--- hw/pib_pkg.sv
// types shared by the packet input block
package pib_pkg;
	typedef enum logic [1:0] {PIB_TT_ORD, PIB_TT_ATOM, PIB_TT_NULL, PIB_TT_RSV} pib_tt_e;
	typedef enum logic [1:0] {PIB_TM_TUPLE, PIB_TM_MASK, PIB_TM_IPSEL, PIB_TM_XOR} pib_tmode_e;
	// per-packet classification from the parser
	typedef struct packed {
		logic        rx_err;
		logic        raw_full_packet;
		logic        raw_scheduled_packet;
		logic        is_ip;
		logic        ip_v6;
		logic        ip_tcp;
		logic        tcp_syn;
		logic        vlan_ok;
		logic        diff_hit;
		logic [7:0]  skip_len;
		logic [7:0]  l2_header_length;
		logic [15:0] pkt_len;
	} pib_pkt_s;
	// scheduling fields of a work-queue entry
	typedef struct packed {
		logic [2:0]  qos;
		logic [3:0]  grp;
		pib_tt_e     tag_type;
		logic [31:0] tag;
	} pib_sched_s;
	typedef logic [63:0] pib_ptr_t;
endpackage

//--- hw/pib_top.sv
// packet buffer pointer formatting, alignment pad and work scheduling fields over apb
//
// Behaviour
// [RQ1] pointer is one 64-bit word; size in 55:40; pool and top bit zero
// [RQ2] address field points at first packet data byte of the buffer
// [RQ3] entry pointer may be unaligned; pointers inside buffers are word aligned
// [RQ4] size is exact byte count except last valid pointer: distance to buffer end
// [RQ5] last valid pointer is entry pointer for one buffer, else second-to-last buffer
// [RQ6] size correction bit 0 at reset makes every size read eight larger
// [RQ7] back field from first or later configured value, in 128-byte blocks
// [RQ8] alignment pad of 0 to 7 bytes before data in first buffer
// [RQ9] error packets up to 128 bytes use non-IP pad setting
// [RQ10] raw full uses raw pad; other non-IP uses non-IP pad; shared
// [RQ11] IP pad is (8 or 4 minus skip plus l2 length) and 7
// [RQ12] IP with version neither 4 nor 6 aligns like IPv4
// [RQ13] endian bit picks byte order of packet words and next pointers
// [RQ14] pad count equal in both orders; entry data unaffected by endian bit
// [RQ15] up to 255 buffers and 65535 bytes per packet
// [RQ16] each kept packet gets queue, group, tag type and 32-bit tag
// [RQ17] raw full and raw scheduled take fields from instruction header
// [RQ18] queue defaults per port, overridden by vlan, diffserv or watcher; here only vlan and diffserv override, no watcher
// [RQ19] group defaults per port; IP may use low tag bits or watcher; here low tag bits only, no watcher
// [RQ20] tag type from four IP settings or one non-IP setting; here one IP field hdr_word[27:26], non-IP hdr_word[25:24]
// [RQ21] tag mode: tuple, mask, tuple-for-IP, or xor of both
// [RQ22] tuple tag xors source and destination hash with secret; syn zeroes source
// [RQ23] mask tag is crc over masked first 128 bytes, up to 16 bits, optional port
// [RQ24] later pointers sit eight bytes before data; first goes into entry
`timescale 1ns/1ps
`default_nettype none
`include "pib_map.svh"

module pib_top #(
	parameter int PORT_W = 4
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire pib_pkg::pib_pkt_s    pkt_info,
	input  wire logic                 pkt_valid,
	input  wire logic [31:0]          hdr_word,
	input  wire logic [15:0]          src_hash,
	input  wire logic [15:0]          dst_hash,
	input  wire logic [15:0]          mask_crc,
	output pib_pkg::pib_ptr_t         ptr_word,
	output logic                      ptr_valid,
	output logic      [39:0]          ptr_waddr,
	output logic                      ptr_to_entry,
	output logic      [2:0]           pad_out,
	output pib_pkg::pib_sched_s       sched_out,
	output logic                      sched_valid
);

	////////////////////////////////////////////////////////////////////////////
	// apb registers
	logic [31:0] ctrl_reg;
	logic [31:0] pad_reg;
	logic [31:0] back_reg;
	logic [31:0] pkt_reg;
	logic [31:0] geo_reg;
	logic [31:0] port_reg;
	logic [31:0] ptr_lo_reg;
	logic [31:0] ptr_hi_reg;
	logic        busy_reg;
	logic        go_reg;
	logic [7:0]  buf_cnt_reg;
	logic [39:0] buf_addr_reg;
	logic [39:0] last_addr_reg;
	logic [15:0] left_reg;

	wire logic wr_en = psel && penable && pwrite;
	wire logic rd_en = psel && penable && !pwrite;

	// control bits: size correction, little endian, pad and back settings
	wire logic       size_correction_enable = ctrl_reg[0];
	wire logic       buffer_little_endian   = ctrl_reg[1];
	wire logic [2:0] nonip_pad_setting      = pad_reg[2:0];
	wire logic [2:0] raw_pad_setting        = pad_reg[6:4];
	wire logic [3:0] first_pointer_back_setting = back_reg[3:0];
	wire logic [3:0] later_pointer_back_setting = back_reg[7:4];

	// address decode for the error response, shared by reads and writes
	function automatic logic known_addr(input logic [11:0] a);
		if (a == `PIB_CTRL_OFF || a == `PIB_PAD_OFF || a == `PIB_BACK_OFF) begin
			return 1'b1;
		end else if (a == `PIB_PKT_OFF || a == `PIB_GEO_OFF || a == `PIB_GO_OFF) begin
			return 1'b1;
		end else if (a == `PIB_PTR_LO_OFF || a == `PIB_PTR_HI_OFF) begin
			return 1'b1;
		end else if (a == `PIB_WQE_OFF || a == `PIB_TAG_OFF) begin
			return 1'b1;
		end else if (a == `PIB_STAT_OFF || a == `PIB_PORT_OFF) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// configuration writes; zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `PIB_CTRL_RST;
			pad_reg  <= 32'h0000_0000;
			back_reg <= 32'h0000_0000;
			pkt_reg  <= 32'h0000_0000;
			geo_reg  <= 32'h0000_0000;
			port_reg <= 32'h0000_0000;
		end else if (wr_en) begin
			if (paddr == `PIB_CTRL_OFF) begin
				ctrl_reg <= pwdata;
			end else if (paddr == `PIB_PAD_OFF) begin
				pad_reg <= pwdata;
			end else if (paddr == `PIB_BACK_OFF) begin
				back_reg <= pwdata;
			end else if (paddr == `PIB_PKT_OFF) begin
				pkt_reg <= pwdata;
			end else if (paddr == `PIB_GEO_OFF) begin
				geo_reg <= pwdata;
			end else if (paddr == `PIB_PORT_OFF) begin
				port_reg <= pwdata;
			end
		end
	end

	// read mux; unmapped addresses error with zero data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !known_addr(paddr);
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (paddr == `PIB_CTRL_OFF) begin
					prdata <= ctrl_reg;
				end else if (paddr == `PIB_PAD_OFF) begin
					prdata <= pad_reg;
				end else if (paddr == `PIB_BACK_OFF) begin
					prdata <= back_reg;
				end else if (paddr == `PIB_PKT_OFF) begin
					prdata <= pkt_reg;
				end else if (paddr == `PIB_GEO_OFF) begin
					prdata <= geo_reg;
				end else if (paddr == `PIB_PTR_LO_OFF) begin
					prdata <= ptr_lo_reg;
				end else if (paddr == `PIB_PTR_HI_OFF) begin
					prdata <= ptr_hi_reg;
				end else if (paddr == `PIB_WQE_OFF) begin
					prdata <= {20'h0_0000, pad_out, sched_out.qos, sched_out.grp,
						sched_out.tag_type};
				end else if (paddr == `PIB_TAG_OFF) begin
					prdata <= sched_out.tag;
				end else if (paddr == `PIB_STAT_OFF) begin
					prdata <= {15'h0000, busy_reg, buf_cnt_reg, 8'h00};
				end else if (paddr == `PIB_PORT_OFF) begin
					prdata <= port_reg;
				end
			end
		end
	end

	// go strobe: pkt_reg holds total length, geo_reg first address bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_reg <= 1'b0;
		end else begin
			go_reg <= wr_en && paddr == `PIB_GO_OFF && !busy_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// alignment pad
	logic [2:0] pad_next;
	logic [7:0] ip_base;
	always_comb begin
		ip_base = pkt_info.ip_v6 ? `PIB_V6_BASE : `PIB_V4_BASE;       // RQ11 RQ12
		if (pkt_info.rx_err) begin
			// long error packets are allowed any pad; reuse the same one
			pad_next = nonip_pad_setting;                           // RQ9
		end else if (pkt_info.raw_full_packet) begin
			pad_next = raw_pad_setting;                             // RQ10
		end else if (pkt_info.is_ip) begin
			pad_next = 3'(ip_base - pkt_info.skip_len - pkt_info.l2_header_length); // RQ11
		end else begin
			pad_next = nonip_pad_setting;                           // RQ10
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scheduling fields
	pib_pkg::pib_sched_s sched_next;
	logic [15:0]         tuple_tag;
	logic [15:0]         base_tag;
	pib_pkg::pib_tmode_e tmode;
	always_comb begin
		tmode     = pib_pkg::pib_tmode_e'(port_reg[1:0]);
		tuple_tag = (pkt_info.tcp_syn && port_reg[2] ? 16'h0000 : src_hash)
			^ dst_hash ^ port_reg[31:16];                           // RQ22
		case (tmode)                                                    // RQ21
			pib_pkg::PIB_TM_TUPLE: base_tag = tuple_tag;
			pib_pkg::PIB_TM_MASK:  base_tag = mask_crc;             // RQ23
			pib_pkg::PIB_TM_IPSEL: base_tag = pkt_info.is_ip ? tuple_tag : mask_crc;
			default:               base_tag = tuple_tag ^ mask_crc;
		endcase
		sched_next.tag = {port_reg[3] ? 12'(port_reg[15:12]) : 12'h000, 4'h0, base_tag}; // RQ23
		sched_next.qos = port_reg[6:4];                                 // RQ18
		if (pkt_info.vlan_ok && port_reg[7]) begin
			sched_next.qos = hdr_word[2:0];
		end
		if (pkt_info.is_ip && pkt_info.diff_hit && port_reg[8]) begin
			sched_next.qos = hdr_word[5:3];
		end
		sched_next.grp = port_reg[12:9];                                // RQ19
		if (pkt_info.is_ip && port_reg[3]) begin
			sched_next.grp = 4'(port_reg[12:9] + base_tag[1:0]);
		end
		if (!pkt_info.is_ip) begin
			sched_next.tag_type = pib_pkg::pib_tt_e'(hdr_word[25:24]); // RQ20
		end else begin
			sched_next.tag_type = pib_pkg::pib_tt_e'(hdr_word[27:26]); // RQ20
		end
		if (pkt_info.raw_full_packet || pkt_info.raw_scheduled_packet) begin // RQ17
			sched_next.qos      = hdr_word[2:0];
			sched_next.grp      = hdr_word[6:3];
			sched_next.tag_type = pib_pkg::pib_tt_e'(hdr_word[8:7]);
			sched_next.tag      = {16'h0000, hdr_word[31:16]};
		end
	end

	// capture one entry per packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sched_out   <= '0;
			sched_valid <= 1'b0;
			pad_out     <= 3'h0;
		end else begin
			sched_valid <= pkt_valid;                                   // RQ16
			if (pkt_valid) begin
				sched_out <= sched_next;
				pad_out   <= pad_next;                                  // RQ8
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pointer walker: one pointer per cycle after go
	logic [15:0] room;
	logic [15:0] sz;
	logic [15:0] bsize;
	logic        last_valid;
	logic [63:0] fmt;
	always_comb begin
		bsize = {geo_reg[31:24], 8'h00};
		// every buffer gives its first word to a pointer slot, so data room starts past it
		room  = buf_cnt_reg == 8'h00 ? 16'(bsize - 16'h0008 - {13'h0000, pad_out})
			: 16'(bsize - 16'h0008);
		last_valid = left_reg <= room || buf_cnt_reg == `PIB_MAX_BUFS - 8'h01; // RQ5 RQ15
		sz = room;                                                      // RQ4
		if (!size_correction_enable) begin
			sz = 16'(room + `PIB_SIZE_ERR);                          // RQ6
		end
		fmt = '0;                                                       // RQ1
		fmt[`PIB_SZ_MSB:`PIB_SZ_LSB]   = sz;
		fmt[`PIB_BACK_MSB:`PIB_BACK_LSB] = buf_cnt_reg == 8'h00 ?
			first_pointer_back_setting : later_pointer_back_setting;    // RQ7
		fmt[39:0] = buf_addr_reg;                                       // RQ2 RQ3
		if (buffer_little_endian && buf_cnt_reg != 8'h00) begin
			fmt = {<<8{fmt}};                                       // RQ13 RQ14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg     <= 1'b0;
			buf_cnt_reg  <= 8'h00;
			buf_addr_reg <= 40'h00_0000_0000;
			last_addr_reg <= 40'h00_0000_0000;
			left_reg     <= 16'h0000;
			ptr_word     <= '0;
			ptr_valid    <= 1'b0;
			ptr_waddr    <= 40'h00_0000_0000;
			ptr_to_entry <= 1'b0;
			ptr_lo_reg   <= 32'h0000_0000;
			ptr_hi_reg   <= 32'h0000_0000;
		end else begin
			ptr_valid <= 1'b0;
			if (go_reg) begin
				busy_reg     <= 1'b1;
				buf_cnt_reg  <= 8'h00;
				left_reg     <= pkt_reg[15:0];
				buf_addr_reg <= {geo_reg[23:0], 13'h0001, pad_out}; // RQ3
			end else if (busy_reg) begin
				ptr_word     <= fmt;
				ptr_valid    <= 1'b1;
				ptr_to_entry <= buf_cnt_reg == 8'h00;                 // RQ24
				// a buffer's pointer sits in the previous buffer's slot; the entry has none
				ptr_waddr    <= buf_cnt_reg == 8'h00 ? 40'h00_0000_0000
					: 40'(last_addr_reg - 40'h00_0000_0008);        // RQ5 RQ24
				last_addr_reg <= buf_addr_reg;
				ptr_lo_reg   <= fmt[31:0];
				ptr_hi_reg   <= fmt[63:32];
				left_reg     <= 16'(left_reg - room);
				buf_cnt_reg  <= buf_cnt_reg + 8'h01;
				// later buffers start word aligned, one word past pointer slot
				buf_addr_reg <= {24'(buf_addr_reg[39:16] + 24'h00_0001), 16'h0008}; // RQ3
				if (last_valid) begin
					busy_reg <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_pool_zero;
		@(posedge pclk) disable iff (!presetn)
		ptr_valid && !buffer_little_endian |-> ptr_word[63:56] == {1'b0, ptr_word[62:59], 3'b000};
	endproperty
	a_pool_zero: assert property (p_pool_zero) else $error("pool or top bit set"); // RQ1

	property p_size_corr;
		@(posedge pclk) disable iff (!presetn)
		busy_reg && !go_reg && !size_correction_enable && !buffer_little_endian
			|=> ptr_word[55:40] == 16'($past(room) + 16'h0008);
	endproperty
	a_size_corr: assert property (p_size_corr) else $error("size not offset by eight"); // RQ6

	property p_later_aligned;
		@(posedge pclk) disable iff (!presetn)
		ptr_valid && !ptr_to_entry && !buffer_little_endian |-> ptr_word[2:0] == 3'h0;
	endproperty
	a_later_aligned: assert property (p_later_aligned) else $error("later pointer unaligned"); // RQ3

	property p_slot;
		@(posedge pclk) disable iff (!presetn)
		ptr_valid && !ptr_to_entry && !buffer_little_endian
			|-> ptr_waddr + 40'h00_0000_0008 == $past(ptr_word[39:0]);
	endproperty
	a_slot: assert property (p_slot) else $error("pointer slot misplaced"); // RQ24

	property p_raw_pad;
		@(posedge pclk) disable iff (!presetn)
		pkt_valid && !pkt_info.rx_err && pkt_info.raw_full_packet
			|=> pad_out == $past(raw_pad_setting);
	endproperty
	a_raw_pad: assert property (p_raw_pad) else $error("raw pad wrong"); // RQ10

	property p_err_pad;
		@(posedge pclk) disable iff (!presetn)
		pkt_valid && pkt_info.rx_err && pkt_info.pkt_len <= `PIB_ERR_LEN_MAX
			|=> pad_out == $past(nonip_pad_setting);
	endproperty
	a_err_pad: assert property (p_err_pad) else $error("error pad wrong"); // RQ9

	property p_raw_sched;
		@(posedge pclk) disable iff (!presetn)
		pkt_valid && pkt_info.raw_scheduled_packet
			|=> sched_out.grp == $past(hdr_word[6:3]) && sched_valid;
	endproperty
	a_raw_sched: assert property (p_raw_sched) else $error("raw group not from header"); // RQ17

	property p_buf_limit;
		@(posedge pclk) disable iff (!presetn)
		busy_reg |-> buf_cnt_reg < `PIB_MAX_BUFS;
	endproperty
	a_buf_limit: assert property (p_buf_limit) else $error("buffer count over limit"); // RQ15

	property p_entry_back;
		@(posedge pclk) disable iff (!presetn)
		ptr_valid && ptr_to_entry |-> ptr_word[62:59] == first_pointer_back_setting;
	endproperty
	a_entry_back: assert property (p_entry_back) else $error("entry back field wrong"); // RQ7

	property p_sched_pulse;
		@(posedge pclk) disable iff (!presetn)
		pkt_valid |=> sched_valid;
	endproperty
	a_sched_pulse: assert property (p_sched_pulse) else $error("no entry for kept packet"); // RQ16

endmodule
`default_nettype wire

//--- sim/pib_far.sv
// far-side model: packet source on the input side, pointer sink on the memory side
`timescale 1ns/1ps
`default_nettype none
module pib_far (
	input  wire logic              pclk,
	input  wire pib_pkg::pib_ptr_t ptr_word,
	input  wire logic              ptr_valid,
	input  wire logic [39:0]       ptr_waddr,
	input  wire logic              ptr_to_entry,
	output pib_pkg::pib_pkt_s      pkt_info,
	output logic                   pkt_valid,
	output logic [31:0]            hdr_word,
	output logic [15:0]            src_hash,
	output logic [15:0]            dst_hash,
	output logic [15:0]            mask_crc
);
	pib_pkg::pib_ptr_t q_word[$];
	logic [39:0]       q_addr[$];
	logic              q_ent[$];
	initial begin
		pkt_info = '0;
		pkt_valid = 1'b0;
		hdr_word = 32'h0000_0000;
		src_hash = 16'h1357;
		dst_hash = 16'h2468;
		mask_crc = 16'h0F1E;
	end
	// memory never stalls, so each pointer lands on the edge it is offered
	always @(posedge pclk) begin
		if (ptr_valid === 1'b1) begin
			q_word.push_back(ptr_word);
			q_addr.push_back(ptr_waddr);
			q_ent.push_back(ptr_to_entry);
		end
	end
	// one packet; released fields show the inverse so stale values never match
	task automatic send(input pib_pkg::pib_pkt_s i, input logic [31:0] h);
		@(posedge pclk);
		pkt_info <= i;
		hdr_word <= h;
		pkt_valid <= 1'b1;
		@(posedge pclk);
		pkt_valid <= 1'b0;
		pkt_info <= ~i;
		hdr_word <= ~h;
		src_hash <= ~src_hash;
		dst_hash <= ~dst_hash;
	endtask
endmodule
`default_nettype wire

//--- sim/pib_top_tb.sv
// self-checking bench for the packet input block
`timescale 1ns/1ps
`default_nettype none
`include "pib_map.svh"
module pib_top_tb;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, hdr_word;
	pib_pkg::pib_pkt_s   pkt_info;
	logic                pkt_valid, ptr_valid, ptr_to_entry, sched_valid;
	logic [15:0]         src_hash, dst_hash, mask_crc;
	pib_pkg::pib_ptr_t   ptr_word;
	logic [39:0]         ptr_waddr;
	logic [2:0]          pad_out;
	pib_pkg::pib_sched_s sched_out;
	int                  bad_count, n_tests;

	pib_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pkt_info(pkt_info), .pkt_valid(pkt_valid),
		.hdr_word(hdr_word), .src_hash(src_hash), .dst_hash(dst_hash),
		.mask_crc(mask_crc), .ptr_word(ptr_word), .ptr_valid(ptr_valid),
		.ptr_waddr(ptr_waddr), .ptr_to_entry(ptr_to_entry), .pad_out(pad_out),
		.sched_out(sched_out), .sched_valid(sched_valid));
	pib_far far (.pclk(pclk), .ptr_word(ptr_word), .ptr_valid(ptr_valid),
		.ptr_waddr(ptr_waddr), .ptr_to_entry(ptr_to_entry), .pkt_info(pkt_info),
		.pkt_valid(pkt_valid), .hdr_word(hdr_word), .src_hash(src_hash),
		.dst_hash(dst_hash), .mask_crc(mask_crc));

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic die();
		chk(1'b0, "wait ran out");
		results();
	endtask
	// apb master: request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) die();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	function automatic pib_pkg::pib_pkt_s mk(input logic e, rf, rs, ip, v6,
			input logic [7:0] sk, l2, input logic [15:0] len);
		mk = '0;
		mk.rx_err = e;
		mk.raw_full_packet = rf;
		mk.raw_scheduled_packet = rs;
		mk.is_ip = ip;
		mk.ip_v6 = v6;
		mk.skip_len = sk;
		mk.l2_header_length = l2;
		mk.pkt_len = len;
	endfunction
	// send one packet and wait for its scheduling result
	task automatic pk(input pib_pkg::pib_pkt_s i, input logic [31:0] h,
			input logic [2:0] ep);
		int k;
		far.send(i, h);
		for (k = 0; k < 8; k++) begin
			@(posedge pclk);
			if (sched_valid === 1'b1) break;
		end
		if (k == 8) die();
		chk(pad_out === ep, "pad value");
	endtask

	////////////////////////////////////////////////////////////////////////
	// reset values and an unmapped access
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		chk(sched_valid === 1'b0 && ptr_valid === 1'b0, "idle after reset");
		apb(1'b0, `PIB_CTRL_OFF, 32'h0000_0000, r, e);
		chk(r === `PIB_CTRL_RST && e === 1'b0, "ctrl reset value");
		apb(1'b0, 12'hFF0, 32'h0000_0000, r, e);
		chk(e === 1'b1 && r === 32'h0000_0000, "unmapped read");
	endtask
	// nonip pad 3, raw pad 5; error overrides IP classification
	task automatic t_pad();
		wr(`PIB_PAD_OFF, 32'h0000_0053);
		pk(mk(1, 0, 0, 0, 0, 8'h00, 8'h00, 16'h0064), 32'h0, 3'h3);
		pk(mk(1, 0, 0, 1, 1, 8'h00, 8'h0E, 16'h0080), 32'h0, 3'h3);
		pk(mk(0, 1, 0, 0, 0, 8'h00, 8'h00, 16'h003C), 32'h0, 3'h5);
		pk(mk(0, 0, 0, 0, 0, 8'h00, 8'h0E, 16'h003C), 32'h0, 3'h3);
		pk(mk(0, 0, 0, 1, 1, 8'h02, 8'h0E, 16'h003C), 32'h0, 3'h0);
		pk(mk(0, 0, 0, 1, 1, 8'h03, 8'h00, 16'h003C), 32'h0, 3'h5);
		pk(mk(0, 0, 0, 1, 0, 8'h05, 8'h14, 16'h003C), 32'h0, 3'h3);
		pk(mk(0, 0, 0, 1, 0, 8'h00, 8'h0E, 16'h003C), 32'h0, 3'h6);
	endtask
	// raw packets take queue, group, tag type and tag from the header, tag types 0 to 2
	task automatic t_raw();
		logic [31:0] h;
		for (int k = 0; k < 6; k++) begin
			h = {16'hC3C3, 7'h00, 2'(k % 3), 7'h2D};
			pk(mk(0, k < 3, k >= 3, 0, 0, 8'h00, 8'h00, 16'h003C), h, k < 3 ? 3'h5 : 3'h3);
			chk(sched_out.qos === h[2:0] && sched_out.grp === h[6:3], "raw qos grp");
			chk(sched_out.tag_type === h[8:7], "raw tag type");
			chk(sched_out.tag === {16'h0000, h[31:16]}, "raw tag");
		end
	endtask
	// per-port queue, group, tag type, tuple and mask tags, entry and tag registers
	task automatic t_sched();
		logic [31:0]       r;
		logic              e;
		logic [15:0]       t;
		pib_pkg::pib_pkt_s i;
		wr(`PIB_PORT_OFF, 32'hA5A5_0AE0);
		t = far.src_hash ^ far.dst_hash ^ 16'hA5A5;
		pk(mk(0, 0, 0, 0, 0, 8'h00, 8'h00, 16'h003C), 32'h0200_0000, 3'h3);
		chk(sched_out.qos === 3'h6 && sched_out.grp === 4'h5, "default qos grp");
		chk(sched_out.tag_type === 2'b10 && sched_out.tag === {16'h0000, t}, "tuple tag");
		apb(1'b0, `PIB_WQE_OFF, 32'h0000_0000, r, e);
		chk(r === {20'h0_0000, 3'h3, 3'h6, 4'h5, 2'b10}, "entry word");
		i = mk(0, 0, 0, 1, 0, 8'h00, 8'h00, 16'h003C);
		i.vlan_ok = 1'b1;
		wr(`PIB_PORT_OFF, 32'hA5A5_0AE1);
		pk(i, 32'h0400_0003, 3'h4);
		chk(sched_out.qos === 3'h3 && sched_out.tag_type === 2'b01, "vlan qos ip type");
		chk(sched_out.grp === 4'h5 && sched_out.tag === 32'h0000_0F1E, "mask tag");
		apb(1'b0, `PIB_TAG_OFF, 32'h0000_0000, r, e);
		chk(r === 32'h0000_0F1E, "tag register");
	endtask
	// pointer chain for a packet of len bytes in 512-byte buffers, pad 6
	task automatic t_ptr(input logic [31:0] ctl, input int len);
		int          left, room, cnt, k;
		logic [39:0] ad, pa;
		logic [15:0] sz;
		pib_pkg::pib_ptr_t w;
		logic [31:0] r;
		logic        e;
		far.q_word.delete();
		far.q_addr.delete();
		far.q_ent.delete();
		pk(mk(0, 0, 0, 1, 0, 8'h00, 8'h0E, 16'(len)), 32'h0, 3'h6);
		wr(`PIB_CTRL_OFF, ctl);
		wr(`PIB_BACK_OFF, 32'h0000_005A);
		wr(`PIB_PKT_OFF, len);
		wr(`PIB_GEO_OFF, 32'h0200_1234);
		left = len;
		room = 498;
		for (cnt = 1; left > room; cnt++) begin
			left -= room;
			room = 504;
		end
		wr(`PIB_GO_OFF, 32'h0000_0001);
		for (k = 0; k < 60 && far.q_word.size() < cnt; k++) @(posedge pclk);
		repeat (5) @(posedge pclk);
		chk(far.q_word.size() === cnt, "pointer count");
		for (int n = 0; n < far.q_word.size() && n < cnt; n++) begin
			pa = ad;
			ad = n == 0 ? {24'h001234, 13'h0001, 3'h6} : {24'h001234 + 24'(n), 16'h0008};
			sz = 16'(n == 0 ? 498 : 504) + (ctl[0] ? 16'h0000 : 16'h0008);
			w = {1'b0, n == 0 ? 4'hA : 4'h5, 3'h0, sz, ad};
			if (n > 0 && ctl[1]) w = {<<8{w}};
			chk(far.q_word[n] === w, "pointer word");
			chk(far.q_ent[n] === (n == 0), "entry flag");
			if (n > 0) chk(far.q_addr[n] === pa - 40'h00_0000_0008, "slot address");
		end
		apb(1'b0, `PIB_STAT_OFF, 32'h0000_0000, r, e);
		chk(r === {16'h0000, 8'(cnt), 8'h00}, "buffer count");
		apb(1'b0, `PIB_PTR_HI_OFF, 32'h0000_0000, r, e);
		chk(r === w[63:32], "last pointer high word");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		bad_count = 0;
		n_tests = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_pad();
		t_raw();
		t_sched();
		t_ptr(32'h0000_0000, 1200);
		t_ptr(32'h0000_0003, 498);
		t_ptr(32'h0000_0003, 499);
		results();
	end
endmodule
`default_nettype wire
